// >>> fic_ctrl.v
/*
 * Mode and protection controller of a parallel NOR flash: command decode,
 * identification (command and elevated-voltage), CFI entry, reset command,
 * protection mode lock register and per-sector hard-protect bits.
 * Assumes all pins are synchronous to clk, a write is taken on the rising
 * edge of we_n with ce_n low, and an external engine runs program/erase.
 */
`timescale 1ns/100ps
`include "fic_ctrl_regs.vh"

module fic_ctrl #(
  parameter AW        = 25,
  parameter SAW       = 9,
  parameter SECTORS   = 512,
  parameter [7:0]  MAKER_ID  = 8'h5A,   // Arbitrary value
  parameter [15:0] DEVICE_ID = 16'h3C3C, // Arbitrary value
  parameter        WP_TOP    = 1'b0
) (
  input  wire          clk,
  input  wire          rstn,
  input  wire          ce_n,
  input  wire          we_n,
  input  wire          oe_n,
  input  wire          byte_n,
  input  wire          a9_hv,
  input  wire [AW-1:0] addr,
  input  wire [15:0]   dq_i,
  output wire [15:0]   dq_o,
  output wire          dq_oe,
  input  wire [15:0]   array_rdata,
  input  wire [15:0]   cfi_rdata,
  input  wire          eng_busy,
  input  wire          eng_fail,
  input  wire          eng_timeout_win,
  input  wire          erase_susp,
  input  wire          prog_susp,
  output wire          eng_start,
  output wire [1:0]    eng_op,
  output wire [AW-1:0] eng_addr,
  output wire [15:0]   eng_data,
  output wire          eng_abort,
  output wire          lock_prog_abort,
  output wire          page_mode_en,
  output wire          array_access_en,
  output wire [1:0]    read_flavour,
  output wire [3:0]    mode,
  output wire          hard_protect_freeze_bit
);

  localparam ST_READ = 4'h0;
  localparam ST_U1   = 4'h1;
  localparam ST_U2   = 4'h2;
  localparam ST_ID   = 4'h3;
  localparam ST_CFI  = 4'h4;
  localparam ST_PROG = 4'h5;
  localparam ST_E1   = 4'h6;
  localparam ST_E2   = 4'h7;
  localparam ST_E3   = 4'h8;
  localparam ST_LOCK = 4'h9;
  localparam ST_HP   = 4'hA;

  localparam SB_IDLE = 3'h0;
  localparam SB_PROG = 3'h1;
  localparam SB_ERA  = 3'h2;
  localparam SB_EXIT = 3'h3;
  localparam SB_OVR  = 3'h4;

  reg  [3:0]         state_reg;
  reg  [2:0]         sub_reg;
  reg                we_q_reg;
  reg  [15:0]        protection_mode_lock_reg;
  reg  [SECTORS-1:0] sector_hard_protect_bit_reg;
  reg  [SECTORS-1:0] sector_protect_override_bit_reg;
  reg                freeze_reg;
  reg  [15:0]        dq_reg;
  reg                dq_oe_reg;
  reg                eng_start_reg;
  reg  [1:0]         eng_op_reg;
  reg  [AW-1:0]      eng_addr_reg;
  reg  [15:0]        eng_data_reg;
  reg                eng_abort_reg;
  reg                lock_abort_reg;
  reg                page_reg;
  reg                access_reg;
  reg  [1:0]         flavour_reg;
  reg  [15:0]        rd_next;
  reg  [15:0]        lk_next;

  wire               wr_stb;
  wire [SAW-1:0]     sa;
  wire               sect_prot;
  wire [7:0]         wcmd;
  wire               busy_ok;
  wire               in_seq;

  // Address match in word or byte mode
  function match;
    input [11:0] a;
    input        word_mode;
    input [11:0] aw;
    input [11:0] ab;
    begin
      match = word_mode ? (a == aw) : (a == ab);
    end
  endfunction

  // Identification word, shared by command and elevated-voltage paths
  function [15:0] id_word;
    input [1:0]  sel;
    input        prot;
    input [15:0] lk;
    begin
      case (sel)
        `FIC_ID_MAKER: id_word = {8'h00, MAKER_ID};
        `FIC_ID_DEV:   id_word = DEVICE_ID;
        `FIC_ID_PROT:  id_word = {15'h0000, prot};
        `FIC_ID_SEC:   id_word = {8'hFF, ~lk[`FIC_LK_FACT], ~lk[`FIC_LK_CUST], 1'b1, WP_TOP, 4'hF};
        default:       id_word = 16'h0000;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe on we_n rising edge with chip selected
  assign wr_stb  = ~we_q_reg & we_n & ~ce_n;
  assign wcmd    = dq_i[7:0];
  assign sa      = addr[AW-1 -: SAW];
  assign busy_ok = ~(eng_busy & ~eng_fail);
  assign in_seq  = (state_reg == ST_PROG) | (state_reg == ST_E1) | (state_reg == ST_E2) | (state_reg == ST_E3);
  assign sect_prot = ~sector_hard_protect_bit_reg[sa] & sector_protect_override_bit_reg[sa];

  ////////////////////////////////////////////////////////////////////////////
  // Lock register program value; only documented bits are writable
  always @* begin
    lk_next = dq_i | ~`FIC_LK_WMASK;
    if (!protection_mode_lock_reg[`FIC_LK_SOLID])
      lk_next[`FIC_LK_PASS] = 1'b1;
    if (!protection_mode_lock_reg[`FIC_LK_PASS])
      lk_next[`FIC_LK_SOLID] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data source; elevated A9 overrides the mode without changing it
  always @* begin
    rd_next = array_rdata;
    if (a9_hv)
      rd_next = id_word(addr[1:0], sect_prot, protection_mode_lock_reg);
    else begin
      case (state_reg)
        ST_ID:   rd_next = id_word(addr[1:0], sect_prot, protection_mode_lock_reg);
        ST_CFI:  rd_next = cfi_rdata;
        ST_LOCK: rd_next = protection_mode_lock_reg;
        ST_HP:   rd_next = {15'h0000, sector_hard_protect_bit_reg[sa]};
        default: rd_next = array_rdata;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus-facing registered outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      we_q_reg    <= 1'b1;
      dq_reg      <= 16'h0000;
      dq_oe_reg   <= 1'b0;
      page_reg    <= 1'b0;
      access_reg  <= 1'b1;
      flavour_reg <= 2'h0;
    end else begin
      we_q_reg    <= we_n;
      dq_reg      <= rd_next;
      dq_oe_reg   <= ~ce_n & ~oe_n & we_n;
      // page reads only in array read
      page_reg    <= (state_reg == ST_READ) & ~a9_hv;
      access_reg  <= (state_reg != ST_HP);
      flavour_reg <= erase_susp ? 2'h1 : (prog_susp ? 2'h2 : 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer and protection state. Nonvolatile bits are held in
  // flops reset to delivery values; a real part keeps them across power.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg                       <= ST_READ;
      sub_reg                         <= SB_IDLE;
      protection_mode_lock_reg        <= `FIC_LK_INIT;
      sector_hard_protect_bit_reg     <= {SECTORS{1'b1}};
      sector_protect_override_bit_reg <= {SECTORS{1'b1}};
      freeze_reg                      <= 1'b1;
      eng_start_reg                   <= 1'b0;
      eng_op_reg                      <= `FIC_OP_PROG;
      eng_addr_reg                    <= {AW{1'b0}};
      eng_data_reg                    <= 16'h0000;
      eng_abort_reg                   <= 1'b0;
      lock_abort_reg                  <= 1'b0;
    end else begin
      eng_start_reg  <= 1'b0;
      eng_abort_reg  <= 1'b0;
      lock_abort_reg <= 1'b0;
      if (wr_stb && busy_ok) begin
        if (wcmd == `FIC_CMD_RESET) begin
          state_reg     <= ST_READ;
          sub_reg       <= SB_IDLE;
          eng_abort_reg <= in_seq | eng_timeout_win | eng_fail;
        end else if (!eng_fail) begin
          case (state_reg)
            ST_READ: begin
              if (match(addr[11:0], byte_n, `FIC_A_UNL1_W, `FIC_A_UNL1_B) && wcmd == `FIC_CMD_UNL1)
                state_reg <= ST_U1;
              else if (match(addr[11:0], byte_n, `FIC_A_CFI_W, `FIC_A_CFI_B) && wcmd == `FIC_CMD_CFI)
                state_reg <= ST_CFI;
            end
            ST_U1: begin
              if (match(addr[11:0], byte_n, `FIC_A_UNL2_W, `FIC_A_UNL2_B) && wcmd == `FIC_CMD_UNL2)
                state_reg <= ST_U2;
              else
                state_reg <= ST_READ;
            end
            ST_U2: begin
              case (wcmd)
                `FIC_CMD_AUTOSEL:  state_reg <= ST_ID;
                `FIC_CMD_PROG:     state_reg <= ST_PROG;
                `FIC_CMD_ERASE:    state_reg <= ST_E1;
                `FIC_CMD_LOCK_ENT: state_reg <= ST_LOCK;
                `FIC_CMD_HP_ENT:   state_reg <= ST_HP;
                default:           state_reg <= ST_READ;
              endcase
              sub_reg <= SB_IDLE;
            end
            ST_PROG: begin
              eng_start_reg <= 1'b1;
              eng_op_reg    <= `FIC_OP_PROG;
              eng_addr_reg  <= addr;
              eng_data_reg  <= dq_i;
              state_reg     <= ST_READ;
            end
            ST_E1: begin
              if (match(addr[11:0], byte_n, `FIC_A_UNL1_W, `FIC_A_UNL1_B) && wcmd == `FIC_CMD_UNL1)
                state_reg <= ST_E2;
              else
                state_reg <= ST_READ;
            end
            ST_E2: begin
              if (match(addr[11:0], byte_n, `FIC_A_UNL2_W, `FIC_A_UNL2_B) && wcmd == `FIC_CMD_UNL2)
                state_reg <= ST_E3;
              else
                state_reg <= ST_READ;
            end
            ST_E3: begin
              if (wcmd == `FIC_CMD_SECT_ER || wcmd == `FIC_CMD_CHIP_ER) begin
                eng_start_reg <= 1'b1;
                eng_op_reg    <= (wcmd == `FIC_CMD_SECT_ER) ? `FIC_OP_SECT_ER : `FIC_OP_CHIP_ER;
                eng_addr_reg  <= addr;
                eng_data_reg  <= dq_i;
              end
              state_reg <= ST_READ;
            end
            ST_LOCK: begin
              case (sub_reg)
                SB_IDLE: begin
                  if (wcmd == `FIC_CMD_PROG)
                    sub_reg <= SB_PROG;
                  else if (wcmd == `FIC_CMD_AUTOSEL)
                    sub_reg <= SB_EXIT;
                end
                SB_PROG: begin
                  if (!dq_i[`FIC_LK_SOLID] && !dq_i[`FIC_LK_PASS])
                    lock_abort_reg <= 1'b1;
                  else
                    protection_mode_lock_reg <= protection_mode_lock_reg & lk_next;
                  sub_reg <= SB_IDLE;
                end
                SB_EXIT: begin
                  if (wcmd == `FIC_CMD_EXIT2)
                    state_reg <= ST_READ;
                  sub_reg <= SB_IDLE;
                end
                default: sub_reg <= SB_IDLE;
              endcase
            end
            ST_HP: begin
              case (sub_reg)
                SB_IDLE: begin
                  case (wcmd)
                    `FIC_CMD_PROG:    sub_reg <= SB_PROG;
                    `FIC_CMD_ERASE:   sub_reg <= SB_ERA;
                    `FIC_CMD_AUTOSEL: sub_reg <= SB_EXIT;
                    `FIC_CMD_OVR:     sub_reg <= SB_OVR;
                    `FIC_CMD_FREEZE:  freeze_reg <= 1'b0;
                    default:          sub_reg <= SB_IDLE;
                  endcase
                end
                SB_PROG: begin
                  if (freeze_reg)
                    sector_hard_protect_bit_reg[sa] <= 1'b0;
                  sub_reg <= SB_IDLE;
                end
                SB_ERA: begin
                  if (freeze_reg && wcmd == `FIC_CMD_SECT_ER)
                    sector_hard_protect_bit_reg <= {SECTORS{1'b1}};
                  sub_reg <= SB_IDLE;
                end
                SB_OVR: begin
                  sector_protect_override_bit_reg[sa] <= dq_i[0];
                  sub_reg <= SB_IDLE;
                end
                SB_EXIT: begin
                  if (wcmd == `FIC_CMD_EXIT2)
                    state_reg <= ST_READ;
                  sub_reg <= SB_IDLE;
                end
                default: sub_reg <= SB_IDLE;
              endcase
            end
            // only reset leaves ID or CFI
            default: state_reg <= state_reg;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output wiring, all from flops
  assign dq_o                    = dq_reg;
  assign dq_oe                   = dq_oe_reg;
  assign eng_start               = eng_start_reg;
  assign eng_op                  = eng_op_reg;
  assign eng_addr                = eng_addr_reg;
  assign eng_data                = eng_data_reg;
  assign eng_abort               = eng_abort_reg;
  assign lock_prog_abort         = lock_abort_reg;
  assign page_mode_en            = page_reg;
  assign array_access_en         = access_reg;
  assign read_flavour            = flavour_reg;
  assign mode                    = state_reg;
  assign hard_protect_freeze_bit = freeze_reg;

endmodule // fic_ctrl

// >>> fic_ctrl_regs.vh
/*
 * Command codes, addresses, field positions and reset values used by the
 * flash identification and protection control block.
 * Assumes the includer works in word or byte addresses and 16-bit data.
 */
`ifndef FIC_CTRL_REGS_VH
`define FIC_CTRL_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Command data codes
`define FIC_CMD_RESET     8'hF0
`define FIC_CMD_UNL1      8'hAA
`define FIC_CMD_UNL2      8'h55
`define FIC_CMD_AUTOSEL   8'h90
`define FIC_CMD_CFI       8'h98
`define FIC_CMD_PROG      8'hA0
`define FIC_CMD_ERASE     8'h80
`define FIC_CMD_SECT_ER   8'h30
`define FIC_CMD_CHIP_ER   8'h10
`define FIC_CMD_LOCK_ENT  8'h40
`define FIC_CMD_HP_ENT    8'hC0
`define FIC_CMD_FREEZE    8'h50
`define FIC_CMD_OVR       8'hE0
`define FIC_CMD_EXIT2     8'h00

////////////////////////////////////////////////////////////////////////////
// Command addresses, low 12 bits, word and byte mode
`define FIC_A_UNL1_W      12'h555
`define FIC_A_UNL1_B      12'hAAA
`define FIC_A_UNL2_W      12'h2AA
`define FIC_A_UNL2_B      12'h555
`define FIC_A_CFI_W       12'h055
`define FIC_A_CFI_B       12'h0AA

////////////////////////////////////////////////////////////////////////////
// Protection mode lock register
`define FIC_LK_FACT       0
`define FIC_LK_SOLID      1
`define FIC_LK_PASS       2
`define FIC_LK_CUST       6
`define FIC_LK_INIT       16'hFFFF
`define FIC_LK_WMASK      16'h0047

////////////////////////////////////////////////////////////////////////////
// Identification select on address bits 1:0
`define FIC_ID_MAKER      2'h0
`define FIC_ID_DEV        2'h1
`define FIC_ID_PROT       2'h2
`define FIC_ID_SEC        2'h3

// Engine operation codes
`define FIC_OP_PROG       2'h0
`define FIC_OP_SECT_ER    2'h1
`define FIC_OP_CHIP_ER    2'h2

`endif

// >>> fic_ctrl_checker.sv
/* Port checker for fic_ctrl: mode, reset, page and protection relations.
   Assumes it is bound onto fic_ctrl, one clock, reset low and async. */
`timescale 1ns/100ps
module fic_ctrl_checker #(
  parameter AW = 25
) (
  input wire          clk,
  input wire          rstn,
  input wire          ce_n,
  input wire          we_n,
  input wire          byte_n,
  input wire          a9_hv,
  input wire [AW-1:0] addr,
  input wire [15:0]   dq_i,
  input wire          eng_busy,
  input wire          eng_fail,
  input wire          eng_abort,
  input wire          lock_prog_abort,
  input wire          page_mode_en,
  input wire          array_access_en,
  input wire [3:0]    mode,
  input wire          hard_protect_freeze_bit
);
////////////////////////////////////////////////////////////////////////////
// Strobe history, so a write counts only on the rise of we_n
reg  we_q_reg;
wire tk = !ce_n && we_n && !we_q_reg;
wire f0 = dq_i[7:0] == 8'hF0;
wire run = eng_busy && !eng_fail;
always @(posedge clk or negedge rstn) begin
  if (!rstn) we_q_reg <= 1'b1;
  else we_q_reg <= we_n;
end
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);
////////////////////////////////////////////////////////////////////////////
property p_id_hold;
  ((mode == 4'h3 || mode == 4'h4) && tk && !f0) |=> $stable(mode);
endproperty
a_id_hold: assert property (p_id_hold)
  else $error("query mode left without reset");
property p_id_page;
  (mode == 4'h3 && $past(mode) == 4'h3) |-> !page_mode_en;
endproperty
a_id_page: assert property (p_id_page)
  else $error("page reads offered in identification");
property p_hv_page;
  a9_hv |=> !page_mode_en;
endproperty
a_hv_page: assert property (p_hv_page)
  else $error("page reads offered under elevated select");
property p_hv_ret;
  ($fell(a9_hv) && mode == 4'h0 && !eng_busy) |-> ##[1:2] page_mode_en;
endproperty
a_hv_ret: assert property (p_hv_ret)
  else $error("no return to read after elevated select");
property p_cfi_ent;
  (tk && mode == 4'h0 && !eng_busy && !eng_fail && dq_i[7:0] == 8'h98
   && addr[11:0] == (byte_n ? 12'h055 : 12'h0AA)) |=> mode == 4'h4;
endproperty
a_cfi_ent: assert property (p_cfi_ent)
  else $error("query command not entered");
property p_rst_exit;
  (tk && f0 && !run && mode inside {4'h1, 4'h2, 4'h3, 4'h4}) |=> mode == 4'h0;
endproperty
a_rst_exit: assert property (p_rst_exit)
  else $error("reset command did not return to read");
property p_fail;
  (tk && eng_fail && f0) |=> eng_abort && mode == 4'h0;
endproperty
a_fail: assert property (p_fail)
  else $error("failed state not cleared by reset");
property p_busy_ign;
  (tk && run) |=> $stable(mode) && !eng_abort;
endproperty
a_busy_ign: assert property (p_busy_ign)
  else $error("write acted on while engine running");
property p_lk_abort;
  lock_prog_abort |-> $past(mode) == 4'h9 && $past(dq_i[2:1]) == 2'b00;
endproperty
a_lk_abort: assert property (p_lk_abort)
  else $error("lock abort without both scheme bits");
property p_freeze;
  !hard_protect_freeze_bit |=> !hard_protect_freeze_bit;
endproperty
a_freeze: assert property (p_freeze)
  else $error("freeze released without reset");
property p_hp_blk;
  (mode == 4'hA && $past(mode) == 4'hA) |-> !array_access_en;
endproperty
a_hp_blk: assert property (p_hp_blk)
  else $error("array open in hard-protect mode");
// Main scenarios reached
c_id: cover property (mode == 4'h3);
c_hp: cover property (mode == 4'hA);
c_lk: cover property (lock_prog_abort);
endmodule // fic_ctrl_checker

bind fic_ctrl fic_ctrl_checker #(.AW(AW)) CHK (.clk(clk), .rstn(rstn), .ce_n(ce_n), .we_n(we_n),
  .byte_n(byte_n), .a9_hv(a9_hv), .addr(addr), .dq_i(dq_i), .eng_busy(eng_busy), .eng_fail(eng_fail),
  .eng_abort(eng_abort), .lock_prog_abort(lock_prog_abort), .page_mode_en(page_mode_en),
  .array_access_en(array_access_en), .mode(mode), .hard_protect_freeze_bit(hard_protect_freeze_bit));

// >>> fic_host.sv
/* Host bus model for fic_ctrl: write, read and release cycles.
   Assumes callers start on the falling clock edge. */
`timescale 1ns/100ps
module fic_host #(
  parameter AW = 25
) (
  input wire          clk,
  output reg          ce_n,
  output reg          we_n,
  output reg          oe_n,
  output reg          a9_hv,
  output reg [AW-1:0] addr,
  output reg [15:0]   dq_i
);
// Extra cycles of we_n low, for slow hosts
integer slow = 0;
// Idle bus from time zero
initial begin
  ce_n = 1'b1;
  we_n = 1'b1;
  oe_n = 1'b1;
  a9_hv = 1'b0;
  addr = '0;
  dq_i = 16'h0000;
end
////////////////////////////////////////////////////////////////////////////
// Write: lines inverted on release so stale values never look valid
task wr(input [AW-1:0] a, input [15:0] d);
  @(negedge clk);
  ce_n = 1'b0;
  we_n = 1'b0;
  addr = a;
  dq_i = d;
  repeat (1 + slow) @(negedge clk);
  we_n = 1'b1;
  @(negedge clk);
  ce_n = 1'b1;
  addr = ~a;
  dq_i = ~d;
endtask
task rd(input [AW-1:0] a, input hv);
  @(negedge clk);
  ce_n = 1'b0;
  oe_n = 1'b0;
  a9_hv = hv;
  addr = a;
  repeat (2) @(negedge clk);
endtask
// Release after a read, in the same step the data was taken
task rel;
  ce_n = 1'b1;
  oe_n = 1'b1;
  a9_hv = 1'b0;
  addr = ~addr;
endtask
endmodule // fic_host

// >>> flash_id_cfi_protection_ctrl_bench.sv
/* Self-checking bench for fic_ctrl: identification, query, reset, lock
   register and hard-protect sequences. Assumes fic_host as bus master. */
`timescale 1ns/100ps
`include "fic_ctrl_regs.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module flash_id_cfi_protection_ctrl_bench;
localparam [7:0]  MK = 8'h5A;                       // Arbitrary value
localparam [24:0] SA = {9'h005, 16'h0000};
localparam [24:0] SB = {9'h006, 16'h0000};
reg         clk = 1'b0, rstn = 1'b0, byte_n = 1'b1;
reg         eng_busy = 1'b0, eng_fail = 1'b0, eng_timeout_win = 1'b0;
reg         erase_susp = 1'b0, prog_susp = 1'b0;
reg  [15:0] array_rdata = 16'h1234, cfi_rdata = 16'h0051;
wire        ce_n, we_n, oe_n, a9_hv, dq_oe, eng_start, eng_abort, lock_prog_abort;
wire        page_mode_en, array_access_en, freeze;
wire [24:0] addr, eng_addr;
wire [15:0] dq_i, dq_o, eng_data;
wire [1:0]  eng_op, read_flavour;
wire [3:0]  mode;
integer     failures = 0, tests_run = 0, n_abort = 0, n_lkab = 0, n_start = 0;
////////////////////////////////////////////////////////////////////////////
// 40 MHz clock
always #12.5 clk = ~clk;
// Pulse counters, sampled on the rising edge
always @(posedge clk) begin
  if (eng_abort === 1'b1) n_abort++;
  if (lock_prog_abort === 1'b1) n_lkab++;
  if (eng_start === 1'b1) n_start++;
end
fic_host HOST (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .a9_hv(a9_hv), .addr(addr), .dq_i(dq_i));
fic_ctrl #(.MAKER_ID(MK)) DUT (.clk(clk), .rstn(rstn), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
  .byte_n(byte_n), .a9_hv(a9_hv), .addr(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
  .array_rdata(array_rdata), .cfi_rdata(cfi_rdata), .eng_busy(eng_busy), .eng_fail(eng_fail),
  .eng_timeout_win(eng_timeout_win), .erase_susp(erase_susp), .prog_susp(prog_susp),
  .eng_start(eng_start), .eng_op(eng_op), .eng_addr(eng_addr), .eng_data(eng_data),
  .eng_abort(eng_abort), .lock_prog_abort(lock_prog_abort), .page_mode_en(page_mode_en),
  .array_access_en(array_access_en), .read_flavour(read_flavour), .mode(mode),
  .hard_protect_freeze_bit(freeze));
////////////////////////////////////////////////////////////////////////////
// Unlocked command, word mode
task cmd(input [7:0] c);
  HOST.wr(25'h555, 16'h00AA);
  HOST.wr(25'h2AA, 16'h0055);
  HOST.wr(25'h555, {8'h00, c});
endtask
// Two-write exit from lock and hard-protect modes
task ex;
  HOST.wr(25'h0, 16'h0090);
  HOST.wr(25'h0, 16'h0000);
endtask
// Masked read compare
task rchk(input string n, input [24:0] a, input hv, input [15:0] m, input [15:0] e);
  HOST.rd(a, hv);
  `CHK(n, e, dq_o & m)
  `CHK("oe", 1'b1, dq_oe)
  HOST.rel();
endtask
task finish_test;
  $display("comparisons %0d mismatches %0d", tests_run, failures);
  if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
  else $display("CHECKS NOT OK");
  $finish;
endtask
// Watchdog, far beyond the few hundred cycles the tests need
initial begin
  #(25 * 6000);
  failures++;
  finish_test;
end
////////////////////////////////////////////////////////////////////////////
initial begin
  repeat (20) @(negedge clk);
  rstn = 1'b1;
  @(negedge clk);
  `CHK("mode", 4'h0, mode)
  `CHK("page", 1'b1, page_mode_en)
  rchk("protect", SA | 25'h2, 1'b1, 16'h0001, 16'h0000);
  $display("delivery test done");
  rchk("maker", 25'h0, 1'b1, 16'h00FF, {8'h00, MK});
  rchk("secure", 25'h3, 1'b1, 16'hFFFF, 16'hFF2F);
  HOST.rd(25'h0, 1'b1);
  `CHK("page hv", 1'b0, page_mode_en)
  HOST.rel();
  repeat (2) @(negedge clk);
  `CHK("page back", 1'b1, page_mode_en)
  rchk("array", SA | 25'h10, 1'b0, 16'hFFFF, array_rdata);
  $display("elevated test done");
  cmd(8'h90);
  `CHK("page id", 1'b0, page_mode_en)
  rchk("id protect", SA | 25'h2, 1'b0, 16'h0001, 16'h0000);
  HOST.wr(25'h055, 16'h0098);
  `CHK("mode", 4'h3, mode)
  HOST.wr(25'h0, 16'h00F0);
  `CHK("mode", 4'h0, mode)
  HOST.slow = 2;
  HOST.wr(25'h055, 16'h0098);
  `CHK("mode", 4'h4, mode)
  rchk("cfi", 25'h10, 1'b0, 16'hFFFF, cfi_rdata);
  HOST.wr(25'h555, 16'h00AA);
  `CHK("mode", 4'h4, mode)
  HOST.wr(25'h0, 16'h00F0);
  `CHK("mode", 4'h0, mode)
  HOST.slow = 0;
  byte_n = 1'b0;
  HOST.wr(25'h0AA, 16'h0098);
  `CHK("mode", 4'h4, mode)
  HOST.wr(25'h0, 16'h00F0);
  byte_n = 1'b1;
  erase_susp = 1'b1;
  cmd(8'h90);
  HOST.wr(25'h0, 16'h00F0);
  `CHK("flavour", 2'h1, read_flavour)
  erase_susp = 1'b0;
  prog_susp = 1'b1;
  cmd(8'h90);
  HOST.wr(25'h0, 16'h00F0);
  `CHK("flavour", 2'h2, read_flavour)
  prog_susp = 1'b0;
  $display("mode test done");
  // Reset partway through a program sequence, then in the erase time-out window
  cmd(8'hA0);
  HOST.wr(25'h0, 16'h00F0);
  `CHK("mode", 4'h0, mode)
  eng_timeout_win = 1'b1;
  HOST.wr(25'h0, 16'h00F0);
  eng_timeout_win = 1'b0;
  @(negedge clk);
  `CHK("aborts", 2, n_abort)
  cmd(8'hA0);
  HOST.wr(SA | 25'h100, 16'hBEEF);
  eng_busy = 1'b1;
  HOST.wr(25'h555, 16'h00AA);
  `CHK("mode", 4'h0, mode)
  HOST.wr(25'h0, 16'h00F0);
  @(negedge clk);
  `CHK("aborts", 2, n_abort)
  `CHK("start", 1, n_start)
  `CHK("op", 2'h0, eng_op)
  `CHK("eaddr", SA | 25'h100, eng_addr)
  `CHK("edata", 16'hBEEF, eng_data)
  eng_fail = 1'b1;
  HOST.wr(25'h0, 16'h00F0);
  @(negedge clk);
  `CHK("aborts", 3, n_abort)
  eng_busy = 1'b0;
  eng_fail = 1'b0;
  // Reset partway through an erase sequence, then a full sector erase
  cmd(8'h80);
  HOST.wr(25'h555, 16'h00AA);
  HOST.wr(25'h0, 16'h00F0);
  @(negedge clk);
  `CHK("aborts", 4, n_abort)
  cmd(8'h80);
  HOST.wr(25'h555, 16'h00AA);
  HOST.wr(25'h2AA, 16'h0055);
  HOST.wr(SB, 16'h0030);
  @(negedge clk);
  `CHK("start", 2, n_start)
  `CHK("op", 2'h1, eng_op)
  `CHK("eaddr", SB, eng_addr)
  $display("reset test done");
  cmd(8'h40);
  `CHK("mode", 4'h9, mode)
  HOST.wr(25'h0, 16'h00A0);
  HOST.wr(25'h0, 16'hFFBE);
  HOST.wr(25'h0, 16'h00A0);
  HOST.wr(25'h0, 16'hFFF9);
  @(negedge clk);
  `CHK("lock aborts", 1, n_lkab)
  // Fixed-protection scheme first, then the other scheme must not take
  HOST.wr(25'h0, 16'h00A0);
  HOST.wr(25'h0, 16'hFFFD);
  HOST.wr(25'h0, 16'h00A0);
  HOST.wr(25'h0, 16'hFFFB);
  rchk("scheme", 25'h0, 1'b0, 16'h0047, 16'h0004);
  ex();
  rchk("secure", 25'h3, 1'b1, 16'hFFFF, 16'hFFEF);
  $display("lock test done");
  cmd(8'hC0);
  // Access flag follows mode one cycle later
  @(negedge clk);
  `CHK("access", 1'b0, array_access_en)
  HOST.wr(25'h0, 16'h00A0);
  HOST.wr(SA, 16'h0000);
  rchk("raw a", SA, 1'b0, 16'h0001, 16'h0000);
  rchk("raw b", SB, 1'b0, 16'h0001, 16'h0001);
  HOST.wr(25'h0, 16'h00E0);
  HOST.wr(SA, 16'h0000);
  ex();
  @(negedge clk);
  `CHK("access", 1'b1, array_access_en)
  rchk("override", SA | 25'h2, 1'b1, 16'h0001, 16'h0000);
  cmd(8'hC0);
  HOST.wr(25'h0, 16'h00E0);
  HOST.wr(SA, 16'h0001);
  ex();
  rchk("protected", SA | 25'h2, 1'b1, 16'h0001, 16'h0001);
  cmd(8'hC0);
  HOST.wr(25'h0, 16'h0080);
  HOST.wr(25'h0, 16'h0030);
  rchk("erased", SA, 1'b0, 16'h0001, 16'h0001);
  HOST.wr(25'h0, 16'h0050);
  `CHK("freeze", 1'b0, freeze)
  HOST.wr(25'h0, 16'h00A0);
  HOST.wr(SA, 16'h0000);
  rchk("frozen", SA, 1'b0, 16'h0001, 16'h0001);
  rstn = 1'b0;
  @(negedge clk);
  rstn = 1'b1;
  @(negedge clk);
  `CHK("freeze", 1'b1, freeze)
  $display("protect test done");
  finish_test;
end
endmodule // flash_id_cfi_protection_ctrl_bench
